//--- cmp_sync_latch.sv
// Timer-synchronising latch for the comparator result
`timescale 1ns/100ps
module cmp_sync_latch (
  input  wire logic clk_i,          // Instruction-cycle clock
  input  wire logic rst_i,          // Synchronous reset, active high
  input  wire logic src_clk_i,      // Gate timer raw source clock level
  input  wire logic presc_clk_i,    // Gate timer prescaler output level
  input  wire logic presc_en_i,     // Gate timer uses its prescaler
  input  wire logic value_i,        // Polarity-adjusted result
  output logic      latched_o,      // Value caught at last falling edge
  output logic      timer_step_o    // Pulse: timer may advance now
);

  logic sel_clk;
  logic sel_prev;
  logic fall_seen;
  logic rise_seen;

  // (R5) Prescaler output clocks latch
  assign sel_clk   = presc_en_i ? presc_clk_i : src_clk_i;
  assign fall_seen = sel_prev & ~sel_clk;
  assign rise_seen = ~sel_prev & sel_clk;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= sel_clk;
    end
  end

  // (R4) Capture on falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latched_o <= 1'b0;
    end else if (fall_seen) begin
      latched_o <= value_i;
    end
  end

  // (R6) Timer steps on rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_step_o <= 1'b0;
    end else begin
      timer_step_o <= rise_seen;
    end
  end

  chk_latch_fall: assert property (@(posedge clk_i) disable iff (rst_i) // (R4)
    fall_seen |=> (latched_o == $past(value_i)))
    else $error("sync latch missed a falling edge");

  chk_latch_stable: assert property (@(posedge clk_i) disable iff (rst_i) // (R6)
    timer_step_o |-> $stable(latched_o))
    else $error("sync latch changed while timer stepped");

  chk_presc_sel: assert property (@(posedge clk_i) disable iff (rst_i) // (R5)
    (presc_en_i && $fell(presc_clk_i) && $past(presc_en_i)) |=> (latched_o == $past(value_i)))
    else $error("prescaler edge did not clock the latch");

endmodule

//--- cmp_output_logic.sv
// Comparator digital wrapper: package, register slave, result path and edge interrupt flag
//
// Overview of operation
// (R1) Speed select resets to 1 (normal); 0 selects slower low-power mode.
// (R2) Hysteresis enable bit switches hysteresis offset onto comparator inputs.
// (R3) Comparator result is offered as gate source for the gate timer.
// (R4) With sync bit set, result is latched on gate timer clock falling edge.
// (R5) When prescaler is used, the prescaler output clocks the latch.
// (R6) Gate timer advances on rising edges, so latch never changes then.
// (R7) Each comparator has rising and falling edge detectors on its output.
// (R8) Enabled rising or falling edge sets the comparator interrupt flag.
// (R9) Software enables on, polarity, speed, interrupt and edge enables for interrupts.
// (R10) Only software clears the interrupt flag, by writing it.
// (R11) Edge arriving during a software clear leaves the flag set.
// (R12) Two-bit positive select picks pin, converter, fixed reference or ground.
// (R13) Two-bit negative select picks one of four analog pins.
// (R14) With comparator off, all comparator inputs are disconnected.
// (R15) Toggling polarity or on bit while off still moves the edge detectors.
// (R16) Port reads return 0 for every pin configured as analog.
// (R17) Result feeds the capture/compare auto-shutdown logic.
// (R18) Software treats result as unknown right after initialisation.
// (R19) Software waits out response time after changing inputs or references.
// (R20) Result is 1 when positive exceeds negative; invert bit complements it.
// (R21) Internal result is latched once per instruction cycle.
// (R22) Output pin enable makes result override the port latch, regardless of on bit.
// (R23) Edge detectors compare current adjusted result with previous cycle's value.
// (R24) Analog comparison arrives as a single-bit input from the analog core.
//
// Local design decisions: the Wishbone slave port and the address map.

package cmp_pkg;
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_FLAG   = 8'h08;
  localparam logic [7:0] OFS_IE     = 8'h0C;
  localparam logic [7:0] OFS_PORT   = 8'h10;
  localparam logic [7:0] OFS_ANALOG_SELECT  = 8'h14;

  // Control A layout: on, result, pin enable, invert, -, speed, hyst, sync
  localparam int BIT_ON     = 7;
  localparam int BIT_RESULT = 6;
  localparam int BIT_PIN_EN = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_SPEED  = 2;
  localparam int BIT_HYST   = 1;
  localparam int BIT_SYNC   = 0;
  // Control B layout: rise en, fall en, pos sel, -, neg sel
  localparam int BIT_RISE_EN = 7;
  localparam int BIT_FALL_EN = 6;
  localparam int POS_SEL_LSB = 4;
  localparam int NEG_SEL_LSB = 0;
  localparam int BIT_FLAG    = 0;
  localparam int BIT_IE      = 0;

  typedef enum logic [1:0] {POS_PIN, POS_CONVERTER, POS_FIXED_VREF, POS_GROUND} pos_src_t;

  typedef struct packed {
    logic on;
    logic pin_en;
    logic invert;
    logic speed;
    logic hyst;
    logic sync;
  } ctrl_a_t;

  typedef struct packed {
    logic     rise_en;
    logic     fall_en;
    pos_src_t pos_sel;
    logic [1:0] neg_sel;
  } ctrl_b_t;

  localparam ctrl_a_t CTRL_A_RST = '{on: 1'b0, pin_en: 1'b0, invert: 1'b0, speed: 1'b1, hyst: 1'b0, sync: 1'b0};
  localparam ctrl_b_t CTRL_B_RST = '{rise_en: 1'b0, fall_en: 1'b0, pos_sel: POS_PIN, neg_sel: 2'h0};
  localparam logic [7:0]  ANALOG_SELECT_RST = 8'hFF;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

`timescale 1ns/100ps
module cmp_output_logic (
  input  wire logic        clk_i,              // 100 MHz instruction-cycle clock
  input  wire logic        rst_i,              // Synchronous reset, active high
  input  wire logic        cyc_i,              // Wishbone cycle
  input  wire logic        stb_i,              // Wishbone strobe
  input  wire logic        we_i,               // Wishbone write enable
  input  wire logic [7:0]  adr_i,              // Wishbone byte address
  input  wire logic [31:0] dat_i,              // Wishbone write data
  input  wire logic [3:0]  sel_i,              // Wishbone byte selects
  output logic      [31:0] dat_o,              // Wishbone read data
  output logic             ack_o,              // Wishbone acknowledge
  input  wire logic        cmp_raw_i,          // Analog core: positive above negative
  input  wire logic        timer_src_clk_i,    // Gate timer source clock level
  input  wire logic        timer_presc_clk_i,  // Gate timer prescaler output level
  input  wire logic        timer_presc_en_i,   // Gate timer prescaler in use
  input  wire logic [7:0]  port_pins_i,        // Digital port pin levels
  output logic             cmp_enable_o,       // Connect comparator inputs
  output logic             speed_select_o,     // 1 normal speed, 0 low power
  output logic             hyst_enable_o,      // Hysteresis offset on
  output logic      [1:0]  pos_input_sel_o,    // Non-inverting input source
  output logic      [1:0]  neg_input_sel_o,    // Inverting input pin
  output logic             gate_src_o,         // Result for gate timer gate
  output logic             timer_step_o,       // Pulse: gate timer may advance
  output logic             shutdown_src_o,     // Result for auto-shutdown
  output logic             pin_out_o,          // Result driven to output pin
  output logic             pin_override_o,     // Result overrides port latch
  output logic             cmp_int_flag_o,     // Sticky interrupt flag
  output logic             cmp_int_enable_o    // Interrupt enable bit
);

  cmp_pkg::ctrl_a_t ctrl_a;
  cmp_pkg::ctrl_b_t ctrl_b;
  logic [7:0] analog_select;
  logic       cmp_int_flag;
  logic       cmp_int_enable;
  logic       pol_q;
  logic       sync_val;
  logic       cmp_result;
  logic       prev_result;
  logic       rise_ev;
  logic       fall_ev;
  logic       set_ev;
  logic       bus_req;
  logic       wr_lane0;
  logic       flag_clear;
  logic [31:0] next_dat;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  assign bus_req  = cyc_i & stb_i;
  // Write takes effect at the edge the master samples ack
  assign wr_lane0 = bus_req & we_i & ack_o & sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req & ~ack_o;
    end
  end

  always_comb begin
    next_dat = cmp_pkg::DATA_ZERO;
    if (hit(adr_i, cmp_pkg::OFS_CTRL_A)) begin
      next_dat[cmp_pkg::BIT_ON]     = ctrl_a.on;
      next_dat[cmp_pkg::BIT_RESULT] = cmp_result;
      next_dat[cmp_pkg::BIT_PIN_EN] = ctrl_a.pin_en;
      next_dat[cmp_pkg::BIT_INVERT] = ctrl_a.invert;
      next_dat[cmp_pkg::BIT_SPEED]  = ctrl_a.speed;
      next_dat[cmp_pkg::BIT_HYST]   = ctrl_a.hyst;
      next_dat[cmp_pkg::BIT_SYNC]   = ctrl_a.sync;
    end else if (hit(adr_i, cmp_pkg::OFS_CTRL_B)) begin
      next_dat[cmp_pkg::BIT_RISE_EN] = ctrl_b.rise_en;
      next_dat[cmp_pkg::BIT_FALL_EN] = ctrl_b.fall_en;
      next_dat[cmp_pkg::POS_SEL_LSB +: 2] = ctrl_b.pos_sel;
      next_dat[cmp_pkg::NEG_SEL_LSB +: 2] = ctrl_b.neg_sel;
    end else if (hit(adr_i, cmp_pkg::OFS_FLAG)) begin
      next_dat[cmp_pkg::BIT_FLAG] = cmp_int_flag;
    end else if (hit(adr_i, cmp_pkg::OFS_IE)) begin
      next_dat[cmp_pkg::BIT_IE] = cmp_int_enable;
    end else if (hit(adr_i, cmp_pkg::OFS_PORT)) begin
      // (R16) Analog pins read as zero
      next_dat[7:0] = port_pins_i & ~analog_select;
    end else if (hit(adr_i, cmp_pkg::OFS_ANALOG_SELECT)) begin
      next_dat[7:0] = analog_select;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= cmp_pkg::DATA_ZERO;
    end else if (bus_req & ~ack_o) begin
      dat_o <= next_dat;
    end
  end

  // (R1) Speed bit resets to normal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a <= cmp_pkg::CTRL_A_RST;
    end else if (wr_lane0 && hit(adr_i, cmp_pkg::OFS_CTRL_A)) begin
      ctrl_a.on     <= dat_i[cmp_pkg::BIT_ON];
      ctrl_a.pin_en <= dat_i[cmp_pkg::BIT_PIN_EN];
      ctrl_a.invert <= dat_i[cmp_pkg::BIT_INVERT];
      ctrl_a.speed  <= dat_i[cmp_pkg::BIT_SPEED];
      ctrl_a.hyst   <= dat_i[cmp_pkg::BIT_HYST];
      ctrl_a.sync   <= dat_i[cmp_pkg::BIT_SYNC];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_b <= cmp_pkg::CTRL_B_RST;
    end else if (wr_lane0 && hit(adr_i, cmp_pkg::OFS_CTRL_B)) begin
      ctrl_b.rise_en <= dat_i[cmp_pkg::BIT_RISE_EN];
      ctrl_b.fall_en <= dat_i[cmp_pkg::BIT_FALL_EN];
      ctrl_b.pos_sel <= cmp_pkg::pos_src_t'(dat_i[cmp_pkg::POS_SEL_LSB +: 2]);
      ctrl_b.neg_sel <= dat_i[cmp_pkg::NEG_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_int_enable <= 1'b0;
      analog_select  <= cmp_pkg::ANALOG_SELECT_RST;
    end else if (wr_lane0) begin
      if (hit(adr_i, cmp_pkg::OFS_IE)) begin
        cmp_int_enable <= dat_i[cmp_pkg::BIT_IE];
      end
      if (hit(adr_i, cmp_pkg::OFS_ANALOG_SELECT)) begin
        analog_select <= dat_i[7:0];
      end
    end
  end

  // (R21) Result latched every cycle; (R15) off forces raw low so on/invert still move it
  // (R20) Invert complements the comparison; (R24) single-bit analog input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_q <= 1'b0;
    end else begin
      pol_q <= (ctrl_a.on & cmp_raw_i) ^ ctrl_a.invert;
    end
  end

  cmp_sync_latch u_sync (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .src_clk_i    (timer_src_clk_i),
    .presc_clk_i  (timer_presc_clk_i),
    .presc_en_i   (timer_presc_en_i),
    .value_i      (pol_q),
    .latched_o    (sync_val),
    .timer_step_o (timer_step_o)
  );

  // (R4) Sync bit picks latched value
  assign cmp_result = ctrl_a.sync ? sync_val : pol_q;

  // (R23) Compare with previous cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_result <= 1'b0;
    end else begin
      prev_result <= cmp_result;
    end
  end

  // (R7) Rising and falling detectors
  assign rise_ev = cmp_result & ~prev_result;
  assign fall_ev = ~cmp_result & prev_result;
  // (R8) Enabled edge raises flag
  assign set_ev  = (rise_ev & ctrl_b.rise_en) | (fall_ev & ctrl_b.fall_en);
  assign flag_clear = wr_lane0 && hit(adr_i, cmp_pkg::OFS_FLAG) && !dat_i[cmp_pkg::BIT_FLAG];

  // (R10) Only software clears; (R11) set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_int_flag <= 1'b0;
    end else if (set_ev) begin
      cmp_int_flag <= 1'b1;
    end else if (flag_clear) begin
      cmp_int_flag <= 1'b0;
    end
  end

  // (R3) Gate feed; (R17) shutdown feed; (R22) pin override ignores on bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_src_o     <= 1'b0;
      shutdown_src_o <= 1'b0;
      pin_out_o      <= 1'b0;
    end else begin
      gate_src_o     <= cmp_result;
      shutdown_src_o <= cmp_result;
      pin_out_o      <= cmp_result;
    end
  end

  // (R14) Inputs follow on bit; (R2) hysteresis; (R12) (R13) input selects
  assign cmp_enable_o     = ctrl_a.on;
  assign speed_select_o   = ctrl_a.speed;
  assign hyst_enable_o    = ctrl_a.hyst;
  assign pos_input_sel_o  = ctrl_b.pos_sel;
  assign neg_input_sel_o  = ctrl_b.neg_sel;
  assign pin_override_o   = ctrl_a.pin_en;
  assign cmp_int_flag_o   = cmp_int_flag;
  assign cmp_int_enable_o = cmp_int_enable;

  chk_speed_reset: assert property (@(posedge clk_i) disable iff (rst_i) $past(rst_i) |-> speed_select_o) // (R1)
    else $error("speed select not 1 after reset");

  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // (R8)
    (rise_ev && ctrl_b.rise_en) or (fall_ev && ctrl_b.fall_en) |=> cmp_int_flag_o)
    else $error("enabled edge did not set flag");

  chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i) // (R10)
    (cmp_int_flag_o && !flag_clear) |=> cmp_int_flag_o)
    else $error("flag cleared without software");

  chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // (R11)
    (set_ev && flag_clear) |=> cmp_int_flag_o)
    else $error("clear beat a simultaneous edge");

  chk_result_pol: assert property (@(posedge clk_i) disable iff (rst_i) // (R20)
    !ctrl_a.sync ##1 !ctrl_a.sync |-> (cmp_result == (($past(ctrl_a.on) & $past(cmp_raw_i)) ^ $past(ctrl_a.invert))))
    else $error("result polarity wrong");

  chk_port_analog: assert property (@(posedge clk_i) disable iff (rst_i) // (R16)
    (bus_req && !ack_o && hit(adr_i, cmp_pkg::OFS_PORT)) |=> ((dat_o[7:0] & $past(analog_select)) == 8'h00))
    else $error("analog pin read nonzero");

  chk_feeds_follow: assert property (@(posedge clk_i) disable iff (rst_i) // (R17)
    1'b1 |=> (shutdown_src_o == $past(cmp_result)) && (gate_src_o == $past(cmp_result)))
    else $error("shutdown or gate feed lags result");

  chk_pin_follow: assert property (@(posedge clk_i) disable iff (rst_i) // (R22)
    pin_override_o ##1 pin_override_o |-> pin_out_o == $past(cmp_result))
    else $error("pin output not result");

endmodule

//--- cmp_gate_timer_model.sv
// Behavioural gate timer: source clock, prescaler and rising-edge count
`timescale 1ns/100ps
module cmp_gate_timer_model (
  input  wire logic       clk_i,       // Instruction-cycle clock
  input  wire logic       rst_i,       // Synchronous reset, active high
  input  wire logic       run_i,       // Source clock runs while high
  input  wire logic       presc_en_i,  // Count prescaler output instead
  output logic            src_clk_o,   // Timer source clock level
  output logic            presc_clk_o, // Prescaler output, source divided by 2
  output logic      [7:0] count_o      // Timer count
);
  logic [1:0] div;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div         <= 2'h0;
      src_clk_o   <= 1'h0;
      presc_clk_o <= 1'h0;
      count_o     <= 8'h00;
    end else if (run_i) begin
      div <= div + 2'h1;
      if (div[0]) begin
        src_clk_o <= ~src_clk_o;
        if (!src_clk_o) begin
          presc_clk_o <= ~presc_clk_o;
          if (!presc_en_i || !presc_clk_o) begin
            count_o <= count_o + 8'h01;
          end
        end
      end
    end
  end
endmodule

//--- comparator_output_logic_test.sv
// Self-checking testbench for the comparator digital wrapper
`timescale 1ns/100ps
module comparator_output_logic_test;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, raw = 1'h0, run = 1'h0, pen = 1'h0;
  logic [7:0]  adr = 8'h00, pins = 8'h00, tcount;
  logic [31:0] dat = 32'h0000_0000, rdat, dat_o;
  logic        ack, gate, step, shut, pin_out, ovr, flag, ie, en, spd, hys, src, presc;
  logic [1:0]  psel, nsel;
  int          fails = 0, n_checks = 0, steps = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (step === 1'h1) steps <= steps + 1;

  cmp_output_logic uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(dat), .sel_i(4'h1), .dat_o(dat_o), .ack_o(ack), .cmp_raw_i(raw),
    .timer_src_clk_i(src), .timer_presc_clk_i(presc), .timer_presc_en_i(pen),
    .port_pins_i(pins), .cmp_enable_o(en), .speed_select_o(spd), .hyst_enable_o(hys),
    .pos_input_sel_o(psel), .neg_input_sel_o(nsel), .gate_src_o(gate),
    .timer_step_o(step), .shutdown_src_o(shut), .pin_out_o(pin_out),
    .pin_override_o(ovr), .cmp_int_flag_o(flag), .cmp_int_enable_o(ie)
  );

  cmp_gate_timer_model tmr_model (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .presc_en_i(pen),
    .src_clk_o(src), .presc_clk_o(presc), .count_o(tcount)
  );

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Raw may rise on the request edge so an edge meets the ack-edge write
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic pr);
    @(posedge clk_i);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat <= d;
    if (pr) raw <= 1'h1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do @(posedge clk_i); while (ack !== 1'h1);
    rdat = dat_o;
    cyc <= 1'h0; stb <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d, 1'h0);
  endtask

  task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
    wb(1'h0, a, 32'h0000_0000, 1'h0);
    check(name, exp, rdat);
  endtask

  task automatic set_raw(input logic v);
    @(posedge clk_i);
    raw <= v;
  endtask

  // Timer stops once the chosen clock has left the level and come back to it
  task automatic tmr(input logic which, input logic lvl);
    logic seen;
    seen = 1'h0;
    @(posedge clk_i);
    run <= 1'h1;
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if ((which ? presc : src) !== lvl) seen = 1'h1;
      else if (seen) break;
    end
    run <= 1'h0;
  endtask

  task automatic count_steps;
    int s0;
    logic [7:0] c0;
    idle(4);
    s0 = steps;
    c0 = tcount;
    @(posedge clk_i);
    run <= 1'h1;
    for (int i = 0; i < 200 && tcount !== c0 + 8'h03; i++) @(posedge clk_i);
    run <= 1'h0;
    idle(4);
    check("timer_steps", 32'h0000_0003, 32'(steps - s0));
  endtask

  task automatic t_reset;
    check("speed_o", 1'h1, spd);
    rd(cmp_pkg::OFS_CTRL_A, "ctrl_a", 32'h0000_0004);
    rd(cmp_pkg::OFS_ANALOG_SELECT, "analog_select", 32'h0000_00FF);
    rd(8'h18, "unmapped", 32'h0000_0000);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0000);
    idle(1);
    check("speed_o", 1'h0, spd);
    $display("test reset done");
  endtask

  task automatic t_select;
    for (int i = 0; i < 4; i++) begin
      wr(cmp_pkg::OFS_CTRL_B, 32'(i * 16 + 3 - i));
      idle(1);
      check("pos_sel", 32'(i), psel);
      check("neg_sel", 32'(3 - i), nsel);
    end
    rd(cmp_pkg::OFS_CTRL_B, "ctrl_b", 32'h0000_0030);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0082);
    idle(1);
    check("enable_o", 1'h1, en);
    check("hyst_o", 1'h1, hys);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0000);
    idle(1);
    check("enable_o", 1'h0, en);
    $display("test select done");
  endtask

  task automatic t_result;
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0080);
    set_raw(1'h1);
    // Let the result settle before trusting it
    idle(3);
    check("gate_src", 1'h1, gate);
    check("shutdown_src", 1'h1, shut);
    rd(cmp_pkg::OFS_CTRL_A, "ctrl_a", 32'h0000_00C0);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0090);
    idle(3);
    check("pin_out", 1'h0, pin_out);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0020);
    idle(1);
    check("pin_override", 1'h1, ovr);
    set_raw(1'h0);
    $display("test result done");
  endtask

  task automatic t_irq;
    // On, speed, edge and interrupt enables
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0084);
    wr(cmp_pkg::OFS_CTRL_B, 32'h0000_00C0);
    wr(cmp_pkg::OFS_IE, 32'h0000_0001);
    wr(cmp_pkg::OFS_FLAG, 32'h0000_0000);
    idle(2);
    check("int_enable", 1'h1, ie);
    check("flag", 1'h0, flag);
    set_raw(1'h1);
    idle(4);
    check("flag", 1'h1, flag);
    rd(cmp_pkg::OFS_FLAG, "flag_reg", 32'h0000_0001);
    set_raw(1'h0);
    idle(4);
    check("flag", 1'h1, flag);
    wr(cmp_pkg::OFS_CTRL_B, 32'h0000_0040);
    wr(cmp_pkg::OFS_FLAG, 32'h0000_0000);
    set_raw(1'h1);
    idle(4);
    check("flag", 1'h0, flag);
    set_raw(1'h0);
    idle(4);
    check("flag", 1'h1, flag);
    wr(cmp_pkg::OFS_CTRL_B, 32'h0000_0080);
    wb(1'h1, cmp_pkg::OFS_FLAG, 32'h0000_0000, 1'h1);
    idle(1);
    check("flag", 1'h1, flag);
    set_raw(1'h0);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0000);
    wr(cmp_pkg::OFS_FLAG, 32'h0000_0000);
    idle(2);
    check("flag", 1'h0, flag);
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0010);
    idle(3);
    check("flag", 1'h1, flag);
    $display("test interrupt done");
  endtask

  // Prescaler falls only when the source rises, so source falls alone must not move the latch
  task automatic t_sync;
    wr(cmp_pkg::OFS_CTRL_A, 32'h0000_0081);
    tmr(1'h0, 1'h0);
    tmr(1'h0, 1'h1);
    set_raw(1'h1);
    idle(6);
    check("gate_src", 1'h0, gate);
    tmr(1'h0, 1'h0);
    idle(4);
    check("gate_src", 1'h1, gate);
    pen <= 1'h1;
    tmr(1'h0, 1'h1);
    set_raw(1'h0);
    tmr(1'h0, 1'h0);
    idle(6);
    check("gate_src", 1'h1, gate);
    tmr(1'h1, 1'h0);
    idle(4);
    check("gate_src", 1'h0, gate);
    count_steps();
    pen <= 1'h0;
    count_steps();
    $display("test sync done");
  endtask

  task automatic t_port;
    wr(cmp_pkg::OFS_ANALOG_SELECT, 32'h0000_000F);
    pins <= 8'hFF;
    rd(cmp_pkg::OFS_PORT, "port", 32'h0000_00F0);
    $display("test port done");
  endtask

  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_select();
    t_result();
    t_irq();
    t_sync();
    t_port();
    results();
  end

  // Whole run needs about 300 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    results();
  end
endmodule
